/* File: rtl/spi_crc_cfg.sv */
// Our own choice: the address-and-strobe port.
`default_nettype none
module spi_crc_cfg
	import spi_crc_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire reg_req_t regReq,
	output logic [31:0] rdata,
	// Link side: serial clock from pin, bit streams
	input wire logic linkClk,
	input wire logic rxBit,
	input wire logic txBit,
	// Core controls
	input wire logic crcEnable,
	input wire logic peripheralResetBit,
	input wire logic frame16,
	input wire logic transferInProgress,
	input wire logic crcCheckStrobe,
	input wire logic [15:0] rxCrcData,
	// Effective audio configuration and CRC mismatch flag
	output audio_cfg_t audioCfg,
	output logic audioActive,
	output logic crcMismatchFlag
);
	typedef struct packed {
		logic [15:0] poly;
		logic [15:0] rxCrc;
		logic [15:0] txCrc;
		logic [11:0] ctl;
		logic mismatch;
		logic crcEnPrev;
		logic [1:0] clkSync;
		logic [1:0] rxSync;
		logic [1:0] txSync;
		logic clkPrev;
		logic [31:0] rdata;
		audio_cfg_t cfgOut;
		logic active;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// One serial step; top term implied by frame width
	function automatic logic [15:0] crcStep(
		input logic [15:0] crc,
		input logic [15:0] poly,
		input logic din,
		input logic wide
	);
		logic fb;
		logic [15:0] sh;
		fb = din ^ (wide ? crc[15] : crc[7]);
		sh = {crc[14:0], 1'b0};
		if (fb)
			sh = sh ^ poly;
		if (!wide)
			sh[15:8] = 8'h00;
		return sh;
	endfunction : crcStep

	logic sampleEdge;
	logic clearAcc;
	logic [11:0] ctlWr;

	always_comb
	begin
		st_nxt = st_r;
		// Synchronisers: first stage feeds only the second
		st_nxt.clkSync = {st_r.clkSync[0], linkClk};
		st_nxt.rxSync = {st_r.rxSync[0], rxBit};
		st_nxt.txSync = {st_r.txSync[0], txBit};
		st_nxt.clkPrev = st_r.clkSync[1];
		st_nxt.crcEnPrev = crcEnable;
		// Bits sampled on rising serial clock after sync
		sampleEdge = st_r.clkSync[1] & ~st_r.clkPrev;
		// Clear on rising CRC enable or peripheral reset
		clearAcc = (crcEnable & ~st_r.crcEnPrev) | peripheralResetBit;
		if (clearAcc)
		begin
			st_nxt.rxCrc = 16'h0000;
			st_nxt.txCrc = 16'h0000;
		end
		else if (crcEnable && sampleEdge)
		begin
			// Wire order already reflects the bit order choice
			st_nxt.rxCrc = crcStep(st_r.rxCrc, st_r.poly,
				st_r.rxSync[1], frame16);
			st_nxt.txCrc = crcStep(st_r.txCrc, st_r.poly,
				st_r.txSync[1], frame16);
		end
		ctlWr = st_r.ctl;
		st_nxt.rdata = 32'h0000_0000;
		// Half-word writes carry the live field in the low lane
		if (regReq.wr)
		begin
			if (regReq.addr == OFS_CRC_POLY)
				st_nxt.poly = regReq.wdata[15:0];
			else if (regReq.addr == OFS_AUDIO_CTL)
			begin
				ctlWr = regReq.wdata[11:0] & CTL_WRITE_MASK;
				// Format fields only accepted while audio disabled
				if (st_r.ctl[CTL_ENABLE_BIT])
				begin
					ctlWr[9:0] = st_r.ctl[9:0];
					ctlWr[CTL_ENABLE_BIT] = regReq.wdata[CTL_ENABLE_BIT];
				end
				// Reserved width code keeps previous setting
				if (ctlWr[CTL_WIDTH_LSB +: 2] == WIDTH_RSVD)
					ctlWr[CTL_WIDTH_LSB +: 2] = st_r.ctl[CTL_WIDTH_LSB +: 2];
				st_nxt.ctl = ctlWr;
			end
			else if (regReq.addr == OFS_CRC_STATUS && !regReq.wdata[0])
				st_nxt.mismatch = 1'b0;
			// Accumulator writes fall through here unused
		end
		else if (regReq.rd)
		begin
			if (regReq.addr == OFS_CRC_POLY)
				st_nxt.rdata = {16'h0000, st_r.poly};
			else if (regReq.addr == OFS_RX_CRC)
				st_nxt.rdata = {16'h0000, st_r.rxCrc};
			else if (regReq.addr == OFS_TX_CRC)
				st_nxt.rdata = {16'h0000, st_r.txCrc};
			else if (regReq.addr == OFS_AUDIO_CTL)
				st_nxt.rdata = {20'h00000, st_r.ctl};
			else if (regReq.addr == OFS_CRC_STATUS)
				st_nxt.rdata = {31'h0, st_r.mismatch};
		end
		// Set wins over a clear in the same cycle
		if (crcCheckStrobe && crcEnable && !st_r.ctl[CTL_PROTO_BIT] &&
			st_r.rxCrc != rxCrcData)
			st_nxt.mismatch = 1'b1;
		// Effective settings: SPI mode masks all audio fields
		if (st_r.ctl[CTL_PROTO_BIT])
		begin
			st_nxt.cfgOut.protocolSelect = 1'b1;
			st_nxt.cfgOut.audioEnable = st_r.ctl[CTL_ENABLE_BIT];
			st_nxt.cfgOut.audioRole = st_r.ctl[CTL_ROLE_LSB +: 2];
			st_nxt.cfgOut.audioStandard = st_r.ctl[CTL_STD_LSB +: 2];
			// Sync length means nothing outside PCM
			st_nxt.cfgOut.pcmSyncLength = st_r.ctl[CTL_PCM_BIT] &&
				st_r.ctl[CTL_STD_LSB +: 2] == STD_PCM;
			st_nxt.cfgOut.clockIdleLevel = st_r.ctl[CTL_CKIDLE_BIT];
			st_nxt.cfgOut.sampleWidth = st_r.ctl[CTL_WIDTH_LSB +: 2];
			st_nxt.cfgOut.slotWidth = st_r.ctl[CTL_SLOT_BIT];
		end
		else
			st_nxt.cfgOut = '0;
		st_nxt.active = st_r.ctl[CTL_PROTO_BIT] & st_r.ctl[CTL_ENABLE_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.poly <= CRC_POLY_RST;
			st_r.ctl <= AUDIO_CTL_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign rdata = st_r.rdata;
	assign audioCfg = st_r.cfgOut;
	assign audioActive = st_r.active;
	assign crcMismatchFlag = st_r.mismatch;
endmodule : spi_crc_cfg
`default_nettype wire

/* File: rtl/spi_crc_cfg_pkg.sv */
`default_nettype none
package spi_crc_cfg_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CRC_POLY = 8'h10;
	localparam logic [7:0] OFS_RX_CRC = 8'h14;
	localparam logic [7:0] OFS_TX_CRC = 8'h18;
	localparam logic [7:0] OFS_AUDIO_CTL = 8'h1c;
	localparam logic [7:0] OFS_CRC_STATUS = 8'h24;
	// Reset values
	localparam logic [15:0] CRC_POLY_RST = 16'h0007;
	localparam logic [11:0] AUDIO_CTL_RST = 12'h000;
	// Control field positions
	localparam int CTL_PROTO_BIT = 11;
	localparam int CTL_ENABLE_BIT = 10;
	localparam int CTL_ROLE_LSB = 8;
	localparam int CTL_PCM_BIT = 7;
	localparam int CTL_STD_LSB = 4;
	localparam int CTL_CKIDLE_BIT = 3;
	localparam int CTL_WIDTH_LSB = 1;
	localparam int CTL_SLOT_BIT = 0;
	localparam logic [11:0] CTL_WRITE_MASK = 12'hfbf;
	// Encodings
	localparam logic [1:0] WIDTH_RSVD = 2'h3;
	localparam logic [1:0] STD_PCM = 2'h3;

	typedef struct packed {
		logic protocolSelect;
		logic audioEnable;
		logic [1:0] audioRole;
		logic pcmSyncLength;
		logic [1:0] audioStandard;
		logic clockIdleLevel;
		logic [1:0] sampleWidth;
		logic slotWidth;
	} audio_cfg_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage : spi_crc_cfg_pkg
`default_nettype wire

/* File: tb/link_partner.sv */
`default_nettype none
module link_partner
(
	// Serial pins toward the block
	output logic sck,
	output logic rx,
	output logic tx
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		sck = 1'b0;
		rx = 1'b0;
		tx = 1'b0;
	end
	// Clock stands still between frames; idle data flips so stale bits
	// cannot pass for fresh ones
	task frame(input logic [15:0] r, t, input int n);
		for (int i = n - 1; i >= 0; i--)
		begin
			rx = r[i];
			tx = t[i];
			#62.5 sck = 1'b1;
			#62.5 sck = 1'b0;
		end
		rx = ~rx;
		tx = ~tx;
	endtask : frame
endmodule : link_partner
`default_nettype wire

/* File: tb/spi_crc_cfg_properties.sv */
`default_nettype none
module spi_crc_cfg_properties
	import spi_crc_cfg_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic rst,
	input wire reg_req_t regReq,
	input wire logic [31:0] rdata,
	input wire logic crcCheckStrobe,
	input wire audio_cfg_t audioCfg,
	input wire logic audioActive,
	input wire logic crcMismatchFlag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rd_idle_a: assert property (!$past(regReq.rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	crc_upper_a: assert property (regReq.rd && regReq.addr < 8'h1c
		|=> rdata[31:16] == 16'h0) else $error("crc upper bits set");
	ctl_rsvd_a: assert property (regReq.rd && regReq.addr == 8'h1c
		|=> rdata[31:12] == 20'h0 && !rdata[6]) else $error("ctl reserved");
	active_cfg_a: assert property (audioActive |-> audioCfg.audioEnable
		&& audioCfg.protocolSelect) else $error("active without enable");
	spi_zero_a: assert property (!audioCfg.protocolSelect
		|-> audioCfg == '0) else $error("audio cfg in spi mode");
	width_rsvd_a: assert property (audioCfg.sampleWidth != WIDTH_RSVD)
		else $error("reserved width taken");
	flag_clear_a: assert property (regReq.wr && regReq.addr == 8'h24
		&& !regReq.wdata[0] && !crcCheckStrobe |=> !crcMismatchFlag)
		else $error("flag not cleared");
	flag_hold_a: assert property (!crcCheckStrobe && !regReq.wr
		|=> $stable(crcMismatchFlag)) else $error("flag moved");
endmodule : spi_crc_cfg_properties
`default_nettype wire

/* File: tb/tb_spi_crc_cfg.sv */
`default_nettype none
module tb_spi_crc_cfg
	import spi_crc_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, crc_enable = 0, pRst = 0, f16 = 0, strb = 0, seenRd = 0;
	logic [15:0] rxCrc = 0, poly, rc, tc, rw, tw;
	logic [31:0] rdata, exq[$];
	reg_req_t rq = '0;
	audio_cfg_t cfg;
	logic act, flag, sck, rxb, txb;
	int err_count = 0, num_checks = 0, seed = 32'hf590a2f2;
	spi_crc_cfg dut(.clk(clk), .rst(rst), .regReq(rq), .rdata(rdata),
		.linkClk(sck), .rxBit(rxb), .txBit(txb), .crcEnable(crc_enable),
		.peripheralResetBit(pRst), .frame16(f16), .transferInProgress(1'b0),
		.crcCheckStrobe(strb), .rxCrcData(rxCrc), .audioCfg(cfg),
		.audioActive(act), .crcMismatchFlag(flag));
	link_partner p(.sck(sck), .rx(rxb), .tx(txb));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) seenRd <= rq.rd;
	always @(negedge clk) if (seenRd) chk(rdata, exq.pop_front());
	task chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) rq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) rq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk) rq <= '{a, 32'h0, 1'b0, 1'b1};
		exq.push_back(e);
		@(posedge clk) rq.rd <= 1'b0;
	endtask : rd
	function logic [15:0] stp(input logic [15:0] c, p, input logic d, w);
		logic f;
		f = d ^ (w ? c[15] : c[7]);
		return ((c << 1) ^ (f ? p : 16'h0)) & (w ? 16'hffff : 16'h00ff);
	endfunction : stp
	task results;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CRC_POLY, 32'h7);
		rd(OFS_RX_CRC, 32'h0);
		poly = $random(seed);
		wr(OFS_CRC_POLY, {16'h0, poly});
		rd(OFS_CRC_POLY, {16'h0, poly});
		wr(OFS_TX_CRC, 32'hffff);
		rd(OFS_TX_CRC, 32'h0);
		for (int w = 0; w < 2; w++)
		begin
			crc_enable <= 1'b0;
			f16 <= w[0];
			@(posedge clk) crc_enable <= 1'b1;
			rc = 0;
			tc = 0;
			rw = $random(seed);
			tw = $random(seed);
			p.frame(rw, tw, w ? 16 : 8);
			for (int i = (w ? 15 : 7); i >= 0; i--)
			begin
				rc = stp(rc, poly, rw[i], w[0]);
				tc = stp(tc, poly, tw[i], w[0]);
			end
			repeat (4) @(posedge clk);
			rd(OFS_RX_CRC, {16'h0, rc});
			rd(OFS_TX_CRC, {16'h0, tc});
		end
		@(posedge clk) strb <= 1'b1;
		rxCrc <= rc ^ 16'h1;
		@(posedge clk) strb <= 1'b0;
		rd(OFS_CRC_STATUS, 32'h1);
		wr(OFS_CRC_STATUS, 32'h0);
		rd(OFS_CRC_STATUS, 32'h0);
		@(posedge clk) pRst <= 1'b1;
		@(posedge clk) pRst <= 1'b0;
		rd(OFS_TX_CRC, 32'h0);
		wr(OFS_AUDIO_CTL, 32'habb);
		rd(OFS_AUDIO_CTL, 32'habb);
		chk({21'h0, cfg}, 32'h57b);
		wr(OFS_AUDIO_CTL, 32'habf);
		rd(OFS_AUDIO_CTL, 32'habb);
		wr(OFS_AUDIO_CTL, 32'hebb);
		wr(OFS_AUDIO_CTL, 32'hc00);
		rd(OFS_AUDIO_CTL, 32'hebb);
		chk({31'h0, act}, 32'h1);
		wr(OFS_AUDIO_CTL, 32'h0);
		rd(OFS_AUDIO_CTL, 32'h2bb);
		chk({21'h0, cfg}, 32'h0);
		results();
	end
	initial
	begin
		#100us;
		err_count++;
		results();
	end
endmodule : tb_spi_crc_cfg
bind spi_crc_cfg spi_crc_cfg_properties prop(.clk(clk), .rst(rst),
	.regReq(regReq), .rdata(rdata), .crcCheckStrobe(crcCheckStrobe),
	.audioCfg(audioCfg), .audioActive(audioActive),
	.crcMismatchFlag(crcMismatchFlag));
`default_nettype wire
